//--- logic/ppmb_pkg.sv
// ----------------------------------------------------------------------------
// Register map, pin packing and reset values
// ----------------------------------------------------------------------------
package ppmb_pkg;
	// Byte offsets of the registers on the AHB-Lite bus.
	localparam logic [7:0] OFF_OUT0 = 8'h00;
	localparam logic [7:0] OFF_DIR0 = 8'h04;
	localparam logic [7:0] OFF_OUT1 = 8'h08;
	localparam logic [7:0] OFF_DIR1 = 8'h0C;
	localparam logic [7:0] OFF_OUT2 = 8'h10;
	localparam logic [7:0] OFF_DIR2 = 8'h14;
	localparam logic [7:0] OFF_OUT3 = 8'h18;
	localparam logic [7:0] OFF_DIR3 = 8'h1C;
	localparam logic [7:0] OFF_OUT5 = 8'h20;
	localparam logic [7:0] OFF_DIR5 = 8'h24;
	localparam logic [7:0] OFF_WPU = 8'h28;
	localparam logic [7:0] OFF_PU2 = 8'h2C;
	localparam logic [7:0] OFF_PU3 = 8'h30;
	localparam logic [7:0] OFF_CTL0 = 8'h34;
	localparam logic [7:0] OFF_CTL2 = 8'h38;
	localparam logic [7:0] OFF_CTL3 = 8'h3C;
	localparam logic [7:0] OFF_EDGE = 8'h40;
	localparam logic [7:0] OFF_PINS = 8'h44;
	localparam logic [7:0] OFF_STS = 8'h4C;
	localparam logic [7:0] OFF_MSK = 8'h50;
	// Positions of each port inside the packed pin vector.
	localparam int POS_P0 = 0;
	localparam int POS_P1 = 4;
	localparam int POS_P2 = 8;
	localparam int POS_P3 = 15;
	localparam int POS_P5 = 19;
	localparam int PIN_W = 23;
	// Field positions.
	localparam int CTL2_ASYNC = 7;
	localparam int EDGE_FALL = 4;
	localparam int STS_KEY = 4;
	// Values after reset.
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [7:0] RST_PU = 8'h00;
	localparam logic [7:0] RST_CTL = 8'h00;
	localparam logic [7:0] RST_EDGE = 8'h00;
	localparam logic [4:0] RST_STS = 5'h00;
	localparam logic [4:0] RST_MSK = 5'h00;
	localparam logic [3:0] RST_KEY = 4'hF;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : ppmb_pkg

//--- logic/ppmb_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Two-stage synchroniser for pin levels
// ----------------------------------------------------------------------------
module ppmb_sync #(parameter int W = 1) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	// The first stage feeds only the second stage, never any logic.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule : ppmb_sync

//--- logic/ppmb_edge.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Edge detector with per-channel rising and falling enables
// ----------------------------------------------------------------------------
module ppmb_edge #(parameter int N = 1) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Synchronised levels and edge enables.
	input wire logic [N-1:0] lvl,
	input wire logic [N-1:0] rise_en,
	input wire logic [N-1:0] fall_en,
	// One-cycle event pulses.
	output logic [N-1:0] evt
);
	logic [N-1:0] prev_ff;
	logic armed_ff;
	wire [N-1:0] rose = lvl & ~prev_ff;
	wire [N-1:0] fell = ~lvl & prev_ff;

	// The first cycle after reset is skipped so a high pin does not fake a rising edge.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_ff <= '0;
			armed_ff <= 1'b0;
			evt <= '0;
		end else begin
			prev_ff <= lvl;
			armed_ff <= 1'b1;
			evt <= armed_ff ? ((rose & rise_en) | (fell & fall_en)) : '0;
		end
	end
endmodule : ppmb_edge

//--- logic/ppmb_top.sv
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Functional notes
// - In control mode the first port feeds its pin levels to key-return detection.
// - Second port: four bits, each direction set by its own direction bit.
// - One shared pull-up option enables second-port pull-ups, input bits only.
// - Third port: seven bits, direction chosen per bit in port mode.
// - Third-port pull-ups enabled per bit, only on input bits.
// - Third-port control mode carries timer output, two serial links, async pins.
// - Fourth port: four bits, per-bit direction and per-bit pull-up option.
// - Fourth-port control mode gives timer clock input, two timer outputs, interrupts.
// - Each external interrupt detects rising, falling or both edges as selected.
// - Fifth port: four-bit open-drain, per-bit direction, no software pull-ups.
// - Reset input is active low; holding it low resets everything.
module ppmb_top
	import ppmb_pkg::*;
(
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// AHB-Lite slave.
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Interrupt.
	output logic IRQ,
	// First port pins.
	input wire logic [3:0] P0_I,
	output logic [3:0] P0_O,
	output logic [3:0] P0_OE,
	output logic [3:0] P0_PU,
	// Second port pins.
	input wire logic [3:0] P1_I,
	output logic [3:0] P1_O,
	output logic [3:0] P1_OE,
	output logic [3:0] P1_PU,
	// Third port pins.
	input wire logic [6:0] P2_I,
	output logic [6:0] P2_O,
	output logic [6:0] P2_OE,
	output logic [6:0] P2_PU,
	// Fourth port pins.
	input wire logic [3:0] P3_I,
	output logic [3:0] P3_O,
	output logic [3:0] P3_OE,
	output logic [3:0] P3_PU,
	// Fifth port open-drain pins.
	input wire logic [3:0] P5_I,
	output logic [3:0] P5_O,
	output logic [3:0] P5_OE,
	// Outputs of the on-chip peripherals.
	input wire logic WIDE_TIMER_OUTPUT,
	input wire logic TIMER_B_OUTPUT,
	input wire logic TIMER_C_OUTPUT,
	input wire logic SERIAL_A_DATA_OUT,
	input wire logic SERIAL_A_CLOCK_OUT,
	input wire logic SERIAL_B_DATA_OUT,
	input wire logic SERIAL_B_CLOCK_OUT,
	input wire logic ASYNC_TRANSMIT_OUT,
	// Inputs of the on-chip peripherals.
	output logic [3:0] KEY_RETURN_INPUTS,
	output logic SERIAL_A_DATA_IN,
	output logic SERIAL_A_CLOCK_IN,
	output logic SERIAL_B_DATA_IN,
	output logic SERIAL_B_CLOCK_IN,
	output logic ASYNC_RECEIVE_IN,
	output logic ASYNC_CLOCK_IN,
	output logic TIMER_C_EXT_COUNT_CLOCK
);
	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	logic [PIN_W-1:0] pin_s;
	logic [4:0] evt;
	logic [3:0] out0_ff, first_port_direction_reg_ff, ctl0_ff;
	logic [3:0] out1_ff, second_port_direction_reg_ff;
	logic [6:0] out2_ff, third_port_direction_reg_ff, third_port_bit_pullup_option_ff;
	logic [7:0] ctl2_ff, edge_ff;
	logic [3:0] out3_ff, fourth_port_direction_reg_ff, fourth_port_bit_pullup_option_ff;
	logic [3:0] ctl3_ff, out5_ff, fifth_port_direction_reg_ff;
	logic [1:0] whole_port_pullup_option_ff;
	logic [4:0] sts_ff, msk_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;

	ppmb_sync #(.W(PIN_W)) u_sync (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.d({P5_I, P3_I, P2_I, P1_I, P0_I}),
		.q(pin_s)
	);

	wire [3:0] p0_s = pin_s[POS_P0 +: 4];
	wire [3:0] p1_s = pin_s[POS_P1 +: 4];
	wire [6:0] p2_s = pin_s[POS_P2 +: 7];
	wire [3:0] p3_s = pin_s[POS_P3 +: 4];
	wire [3:0] p5_s = pin_s[POS_P5 +: 4];
	// Key-return idles high; a low on any routed key pin is a key press.
	wire key_idle = &(p0_s | ~ctl0_ff);

	// Channels 0..3 are the fourth-port interrupts, channel 4 the key return.
	ppmb_edge #(.N(5)) u_edge (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.lvl({key_idle, p3_s}),
		.rise_en({1'b0, edge_ff[3:0] & ctl3_ff}),
		.fall_en({|ctl0_ff, edge_ff[EDGE_FALL +: 4] & ctl3_ff}),
		.evt(evt)
	);

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	function automatic logic hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
		return pend && (a == off);
	endfunction : hit

	// Only whole-word transfers are taken; other sizes complete with no effect.
	wire acc = HSEL && HTRANS[1] && HREADY && (HSIZE == HSIZE_WORD);
	wire rd_acc = acc && !HWRITE;
	wire [7:0] ra = HADDR[7:0];
	wire [7:0] wa = wr_addr_ff;
	wire w_out0 = hit(wr_pend_ff, wa, OFF_OUT0);
	wire w_dir0 = hit(wr_pend_ff, wa, OFF_DIR0);
	wire w_out1 = hit(wr_pend_ff, wa, OFF_OUT1);
	wire w_dir1 = hit(wr_pend_ff, wa, OFF_DIR1);
	wire w_out2 = hit(wr_pend_ff, wa, OFF_OUT2);
	wire w_dir2 = hit(wr_pend_ff, wa, OFF_DIR2);
	wire w_out3 = hit(wr_pend_ff, wa, OFF_OUT3);
	wire w_dir3 = hit(wr_pend_ff, wa, OFF_DIR3);
	wire w_out5 = hit(wr_pend_ff, wa, OFF_OUT5);
	wire w_dir5 = hit(wr_pend_ff, wa, OFF_DIR5);
	wire w_wpu = hit(wr_pend_ff, wa, OFF_WPU);
	wire w_pu2 = hit(wr_pend_ff, wa, OFF_PU2);
	wire w_pu3 = hit(wr_pend_ff, wa, OFF_PU3);
	wire w_ctl0 = hit(wr_pend_ff, wa, OFF_CTL0);
	wire w_ctl2 = hit(wr_pend_ff, wa, OFF_CTL2);
	wire w_ctl3 = hit(wr_pend_ff, wa, OFF_CTL3);
	wire w_edge = hit(wr_pend_ff, wa, OFF_EDGE);
	wire w_sts = hit(wr_pend_ff, wa, OFF_STS);
	wire w_msk = hit(wr_pend_ff, wa, OFF_MSK);

	// ------------------------------------------------------------------------
	// Next register values
	// ------------------------------------------------------------------------
	// Writes land at the end of the data phase and act on the pins at that same edge.
	wire [3:0] nxt_out0 = w_out0 ? HWDATA[3:0] : out0_ff;
	wire [3:0] nxt_dir0 = w_dir0 ? HWDATA[3:0] : first_port_direction_reg_ff;
	wire [3:0] nxt_out1 = w_out1 ? HWDATA[3:0] : out1_ff;
	wire [3:0] nxt_dir1 = w_dir1 ? HWDATA[3:0] : second_port_direction_reg_ff;
	wire [6:0] nxt_out2 = w_out2 ? HWDATA[6:0] : out2_ff;
	wire [6:0] nxt_dir2 = w_dir2 ? HWDATA[6:0] : third_port_direction_reg_ff;
	wire [3:0] nxt_out3 = w_out3 ? HWDATA[3:0] : out3_ff;
	wire [3:0] nxt_dir3 = w_dir3 ? HWDATA[3:0] : fourth_port_direction_reg_ff;
	wire [3:0] nxt_out5 = w_out5 ? HWDATA[3:0] : out5_ff;
	wire [3:0] nxt_dir5 = w_dir5 ? HWDATA[3:0] : fifth_port_direction_reg_ff;
	wire [1:0] nxt_wpu = w_wpu ? HWDATA[1:0] : whole_port_pullup_option_ff;
	wire [6:0] nxt_pu2 = w_pu2 ? HWDATA[6:0] : third_port_bit_pullup_option_ff;
	wire [3:0] nxt_pu3 = w_pu3 ? HWDATA[3:0] : fourth_port_bit_pullup_option_ff;
	wire [3:0] nxt_ctl0 = w_ctl0 ? HWDATA[3:0] : ctl0_ff;
	wire [7:0] nxt_ctl2 = w_ctl2 ? HWDATA[7:0] : ctl2_ff;
	wire [3:0] nxt_ctl3 = w_ctl3 ? HWDATA[3:0] : ctl3_ff;
	wire [7:0] nxt_edge = w_edge ? HWDATA[7:0] : edge_ff;
	wire [4:0] nxt_msk = w_msk ? HWDATA[4:0] : msk_ff;
	// A new event wins over a write-one-to-clear in the same cycle.
	wire [4:0] nxt_sts = (sts_ff & ~(w_sts ? HWDATA[4:0] : 5'h00)) | evt;

	// ------------------------------------------------------------------------
	// Pin drive and pull-ups
	// ------------------------------------------------------------------------
	// Direction bit high means output; key-return pins are always inputs.
	wire async_sel = nxt_ctl2[CTL2_ASYNC];
	wire [6:0] alt2 = {WIDE_TIMER_OUTPUT, 1'b0,
		async_sel ? ASYNC_TRANSMIT_OUT : SERIAL_B_DATA_OUT,
		SERIAL_B_CLOCK_OUT, 1'b0, SERIAL_A_DATA_OUT, SERIAL_A_CLOCK_OUT};
	wire [3:0] alt3 = {1'b0, TIMER_C_OUTPUT, TIMER_B_OUTPUT, 1'b0};
	wire [3:0] nxt_oe0 = nxt_dir0 & ~nxt_ctl0;
	wire [3:0] nxt_pu0 = {4{nxt_wpu[0]}} & ~nxt_oe0;
	wire [3:0] nxt_pu1 = {4{nxt_wpu[1]}} & ~nxt_dir1;
	wire [6:0] nxt_o2 = (nxt_ctl2[6:0] & alt2) | (~nxt_ctl2[6:0] & nxt_out2);
	wire [6:0] nxt_pu2_pin = nxt_pu2 & ~nxt_dir2;
	wire [3:0] nxt_o3 = (nxt_ctl3 & alt3) | (~nxt_ctl3 & nxt_out3);
	wire [3:0] nxt_pu3_pin = nxt_pu3 & ~nxt_dir3;
	// Open drain only ever pulls low; a one in the latch releases the pin.
	wire [3:0] nxt_oe5 = nxt_dir5 & ~nxt_out5;

	// Every pad signal is a flop so the pins never glitch on decode.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			P0_OE <= RST_DIR[3:0];
			P1_OE <= RST_DIR[3:0];
			P2_OE <= RST_DIR[6:0];
			P3_OE <= RST_DIR[3:0];
			P5_OE <= RST_DIR[3:0];
		end else begin
			P0_OE <= nxt_oe0;
			P1_OE <= nxt_dir1;
			P2_OE <= nxt_dir2;
			P3_OE <= nxt_dir3;
			P5_OE <= nxt_oe5;
		end
	end

	// Output values and pull-up enables.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			{P0_O, P1_O, P3_O, P5_O} <= {RST_OUT[7:0], RST_OUT[7:0]};
			P2_O <= RST_OUT[6:0];
			{P0_PU, P1_PU, P3_PU} <= {RST_PU[3:0], RST_PU[7:0]};
			P2_PU <= RST_PU[6:0];
		end else begin
			{P0_O, P1_O, P3_O, P5_O} <= {nxt_out0, nxt_out1, nxt_o3, 4'h0};
			P2_O <= nxt_o2;
			{P0_PU, P1_PU, P3_PU} <= {nxt_pu0, nxt_pu1, nxt_pu3_pin};
			P2_PU <= nxt_pu2_pin;
		end
	end

	// ------------------------------------------------------------------------
	// Routing of pin levels to peripherals
	// ------------------------------------------------------------------------
	// Unrouted peripheral inputs rest low, key returns rest high.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			KEY_RETURN_INPUTS <= RST_KEY;
			{SERIAL_A_DATA_IN, SERIAL_A_CLOCK_IN, SERIAL_B_DATA_IN} <= 3'h0;
			{SERIAL_B_CLOCK_IN, ASYNC_RECEIVE_IN, ASYNC_CLOCK_IN} <= 3'h0;
			TIMER_C_EXT_COUNT_CLOCK <= 1'b0;
		end else begin
			KEY_RETURN_INPUTS <= p0_s | ~ctl0_ff;
			SERIAL_A_CLOCK_IN <= ctl2_ff[0] & p2_s[0];
			SERIAL_A_DATA_IN <= ctl2_ff[2] & p2_s[2];
			SERIAL_B_CLOCK_IN <= ctl2_ff[3] & ~ctl2_ff[CTL2_ASYNC] & p2_s[3];
			ASYNC_CLOCK_IN <= ctl2_ff[3] & ctl2_ff[CTL2_ASYNC] & p2_s[3];
			SERIAL_B_DATA_IN <= ctl2_ff[5] & ~ctl2_ff[CTL2_ASYNC] & p2_s[5];
			ASYNC_RECEIVE_IN <= ctl2_ff[5] & ctl2_ff[CTL2_ASYNC] & p2_s[5];
			TIMER_C_EXT_COUNT_CLOCK <= ctl3_ff[1] & p3_s[1];
		end
	end

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	// Synchronous active-low reset returns every control bit to its idle value.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			{out0_ff, first_port_direction_reg_ff, ctl0_ff} <= {RST_OUT[3:0], RST_DIR[3:0], RST_CTL[3:0]};
			{out1_ff, second_port_direction_reg_ff} <= {RST_OUT[3:0], RST_DIR[3:0]};
			{out2_ff, third_port_direction_reg_ff} <= {RST_OUT[6:0], RST_DIR[6:0]};
			{out3_ff, fourth_port_direction_reg_ff} <= {RST_OUT[3:0], RST_DIR[3:0]};
			{out5_ff, fifth_port_direction_reg_ff} <= {RST_OUT[3:0], RST_DIR[3:0]};
			whole_port_pullup_option_ff <= RST_PU[1:0];
			third_port_bit_pullup_option_ff <= RST_PU[6:0];
			fourth_port_bit_pullup_option_ff <= RST_PU[3:0];
			{ctl2_ff, ctl3_ff, edge_ff} <= {RST_CTL, RST_CTL[3:0], RST_EDGE};
			{sts_ff, msk_ff} <= {RST_STS, RST_MSK};
		end else begin
			{out0_ff, first_port_direction_reg_ff, ctl0_ff} <= {nxt_out0, nxt_dir0, nxt_ctl0};
			{out1_ff, second_port_direction_reg_ff} <= {nxt_out1, nxt_dir1};
			{out2_ff, third_port_direction_reg_ff} <= {nxt_out2, nxt_dir2};
			{out3_ff, fourth_port_direction_reg_ff} <= {nxt_out3, nxt_dir3};
			{out5_ff, fifth_port_direction_reg_ff} <= {nxt_out5, nxt_dir5};
			whole_port_pullup_option_ff <= nxt_wpu;
			third_port_bit_pullup_option_ff <= nxt_pu2;
			fourth_port_bit_pullup_option_ff <= nxt_pu3;
			{ctl2_ff, ctl3_ff, edge_ff} <= {nxt_ctl2, nxt_ctl3, nxt_edge};
			{sts_ff, msk_ff} <= {nxt_sts, nxt_msk};
		end
	end

	// Read data use the next values so a read right after a write sees it.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (ra)
			OFF_OUT0: rd_mux[3:0] = nxt_out0;
			OFF_DIR0: rd_mux[3:0] = nxt_dir0;
			OFF_OUT1: rd_mux[3:0] = nxt_out1;
			OFF_DIR1: rd_mux[3:0] = nxt_dir1;
			OFF_OUT2: rd_mux[6:0] = nxt_out2;
			OFF_DIR2: rd_mux[6:0] = nxt_dir2;
			OFF_OUT3: rd_mux[3:0] = nxt_out3;
			OFF_DIR3: rd_mux[3:0] = nxt_dir3;
			OFF_OUT5: rd_mux[3:0] = nxt_out5;
			OFF_DIR5: rd_mux[3:0] = nxt_dir5;
			OFF_WPU: rd_mux[1:0] = nxt_wpu;
			OFF_PU2: rd_mux[6:0] = nxt_pu2;
			OFF_PU3: rd_mux[3:0] = nxt_pu3;
			OFF_CTL0: rd_mux[3:0] = nxt_ctl0;
			OFF_CTL2: rd_mux[7:0] = nxt_ctl2;
			OFF_CTL3: rd_mux[3:0] = nxt_ctl3;
			OFF_EDGE: rd_mux[7:0] = nxt_edge;
			OFF_PINS: rd_mux[PIN_W-1:0] = {p5_s, p3_s, p2_s, p1_s, p0_s};
			OFF_STS: rd_mux[4:0] = nxt_sts;
			OFF_MSK: rd_mux[4:0] = nxt_msk;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Zero-wait slave: the address phase is latched, data complete one cycle later.
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			{wr_pend_ff, wr_addr_ff, HRDATA} <= {1'b0, 8'h00, 32'h0000_0000};
			{HREADYOUT, HRESP, IRQ} <= 3'h4;
		end else begin
			wr_pend_ff <= acc && HWRITE;
			wr_addr_ff <= HREADY ? ra : wr_addr_ff;
			HRDATA <= rd_acc ? rd_mux : HRDATA;
			{HREADYOUT, HRESP} <= 2'h2;
			IRQ <= |(nxt_sts & nxt_msk);
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	a_reset_inputs: assert property ($past(!RESETN) |-> (P0_OE | P1_OE | P3_OE | P5_OE) == 4'h0
		&& P2_OE == 7'h00 && (P0_PU | P1_PU | P3_PU) == 4'h0)
		else $error("Pins not released as inputs after reset");
	a_reset_low: assert property ((RESETN && $past(!RESETN)) |-> KEY_RETURN_INPUTS == RST_KEY
		&& !IRQ)
		else $error("Reset did not clear state");
	a_key_route: assert property (ctl0_ff == 4'hF ##1 ctl0_ff == 4'hF
		|-> KEY_RETURN_INPUTS == $past(p0_s) && P0_OE == 4'h0)
		else $error("Key-return pins not routed");
	a_p1_dir: assert property (P1_OE == second_port_direction_reg_ff)
		else $error("Second port direction mismatch");
	a_p1_pullup: assert property (P1_PU == ({4{whole_port_pullup_option_ff[1]}}
		& ~second_port_direction_reg_ff))
		else $error("Second port pull-up mismatch");
	a_p2_portmode: assert property (((P2_OE ^ third_port_direction_reg_ff) == 7'h00)
		&& (P2_PU == (third_port_bit_pullup_option_ff & ~third_port_direction_reg_ff)))
		else $error("Third port direction or pull-up mismatch");
	a_p2_timer: assert property (ctl2_ff[6] |-> P2_O[6] == $past(WIDE_TIMER_OUTPUT))
		else $error("Wide timer output not on pin");
	a_p3_pullup: assert property (P3_PU == (fourth_port_bit_pullup_option_ff
		& ~fourth_port_direction_reg_ff))
		else $error("Fourth port pull-up mismatch");
	a_timer_clk: assert property (ctl3_ff[1] |=> TIMER_C_EXT_COUNT_CLOCK == $past(p3_s[1]))
		else $error("Timer count clock not routed");
	a_ext_rise: assert property (ctl3_ff[0] && edge_ff[0] && $rose(p3_s[0]) && $stable(ctl3_ff)
		&& $stable(edge_ff) |=> ##1 sts_ff[0])
		else $error("Rising edge did not set status");
	a_open_drain: assert property (P5_O == 4'h0 && P5_OE == (fifth_port_direction_reg_ff
		& ~out5_ff))
		else $error("Open-drain pin drives high");
	a_reg_write: assert property (w_dir2 |=> third_port_direction_reg_ff == $past(HWDATA[6:0])
		&& P2_OE == $past(HWDATA[6:0]))
		else $error("Direction write not effective next cycle");

	c_key_event: cover property (evt[STS_KEY] ##1 sts_ff[STS_KEY]);
	c_both_edges: cover property (ctl3_ff[2] && edge_ff[2] && edge_ff[6] && evt[2] ##[1:20] evt[2]);
	c_irq: cover property (!IRQ ##1 IRQ);
	c_serial_mode: cover property (ctl2_ff[CTL2_ASYNC] && ctl2_ff[5] && ASYNC_RECEIVE_IN);
endmodule : ppmb_top

//--- verif/ppmb_board.sv
`timescale 1ns/1ns
// ------
// Board-side model of the port pins
// ------
module ppmb_board (
	// Clock.
	input wire logic clk,
	// Device side of each pin.
	input wire logic [22:0] o,
	input wire logic [22:0] oe,
	input wire logic [22:0] pu,
	// Board drivers.
	input wire logic [22:0] drv_en,
	input wire logic [22:0] drv_val,
	// Resolved pin levels.
	output logic [22:0] pin
);
	logic [22:0] spin = 23'h000000;
	// A floating pin wanders every cycle, so nothing may lean on its last value.
	always_ff @(posedge clk) begin
		spin <= ~spin;
	end
	// The device wins, then the board, then a pull-up, else noise.
	assign pin = (oe & o) | (~oe & ((drv_en & drv_val) | (~drv_en & (pu | spin))));
endmodule : ppmb_board

//--- verif/test_port_pin_mux_block.sv
`timescale 1ns/1ns
// ------
// Self-checking bench for the port block
// ------
module test_port_pin_mux_block
	import ppmb_pkg::*;
;
	logic SYS_CLK, RESETN, HSEL, HWRITE, IRQ, HREADYOUT, HRESP;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	logic [3:0] P0_O, P0_OE, P0_PU, P1_O, P1_OE, P1_PU, P3_O, P3_OE, P3_PU, P5_O, P5_OE;
	logic [6:0] P2_O, P2_OE, P2_PU, rin;
	logic [3:0] KEY_RETURN_INPUTS;
	logic [22:0] drv_en, drv_val;
	logic [7:0] per;
	wire [22:0] pin;
	wire HREADY = HREADYOUT;
	wire [3:0] P0_I = pin[3:0];
	wire [3:0] P1_I = pin[7:4];
	wire [6:0] P2_I = pin[14:8];
	wire [3:0] P3_I = pin[18:15];
	wire [3:0] P5_I = pin[22:19];
	int err_total = 0;
	int checks_done = 0;
	// Device under test.
	ppmb_top uut (.SYS_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
		.HRDATA, .HREADYOUT, .HRESP, .IRQ, .P0_I, .P0_O, .P0_OE, .P0_PU, .P1_I, .P1_O, .P1_OE,
		.P1_PU, .P2_I, .P2_O, .P2_OE, .P2_PU, .P3_I, .P3_O, .P3_OE, .P3_PU, .P5_I, .P5_O, .P5_OE,
		.WIDE_TIMER_OUTPUT(per[7]), .TIMER_B_OUTPUT(per[6]), .TIMER_C_OUTPUT(per[5]),
		.SERIAL_A_DATA_OUT(per[4]), .SERIAL_A_CLOCK_OUT(per[3]), .SERIAL_B_DATA_OUT(per[2]),
		.SERIAL_B_CLOCK_OUT(per[1]), .ASYNC_TRANSMIT_OUT(per[0]), .KEY_RETURN_INPUTS,
		.SERIAL_A_CLOCK_IN(rin[6]), .SERIAL_A_DATA_IN(rin[5]), .SERIAL_B_CLOCK_IN(rin[4]),
		.SERIAL_B_DATA_IN(rin[3]), .ASYNC_CLOCK_IN(rin[2]), .ASYNC_RECEIVE_IN(rin[1]),
		.TIMER_C_EXT_COUNT_CLOCK(rin[0]));
	// Port 5 pull-ups are a fixed mask option, so they are always on here.
	ppmb_board board (.clk(SYS_CLK), .o({P5_O, P3_O, P2_O, P1_O, P0_O}),
		.oe({P5_OE, P3_OE, P2_OE, P1_OE, P0_OE}), .pu({4'hF, P3_PU, P2_PU, P1_PU, P0_PU}),
		.drv_en(drv_en), .drv_val(drv_val), .pin(pin));
	// Clock at 125 MHz.
	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	// ------
	// Shared tasks
	// ------
	task stop_test();
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : tick
	// One single AHB-Lite transfer; the wait has no fixed length.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge SYS_CLK);
		HSEL <= 1'b1;
		HADDR <= {24'h000000, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge SYS_CLK); while (HREADY !== 1'b1);
		q = HRDATA;
		#1;
	endtask : xfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h00000000, q);
		chk(q, e);
	endtask : rdc
	task drive(input logic [22:0] e, input logic [22:0] v, input logic [7:0] p);
		@(posedge SYS_CLK);
		drv_en <= e;
		drv_val <= v;
		per <= p;
	endtask : drive
	// ------
	// Scenarios
	// ------
	task t_reset();
		chk({P0_OE, P1_OE, P2_OE, P3_OE, P5_OE}, 32'h0);
		chk({P0_PU, P1_PU, P2_PU, P3_PU}, 32'h0);
		chk({P0_O, P1_O, P2_O, P3_O, P5_O, rin}, 32'h0);
		chk({KEY_RETURN_INPUTS, IRQ, HREADYOUT, HRESP}, 7'h7A);
		rdc(OFF_CTL2, 32'h0);
	endtask : t_reset
	task t_dir();
		wr(OFF_DIR1, 32'h5);
		wr(OFF_OUT1, 32'h3);
		chk({P1_OE, P1_O & P1_OE}, 8'h51);
		wr(OFF_DIR2, 32'h55);
		wr(OFF_OUT2, 32'h7F);
		chk({P2_OE, P2_O & P2_OE}, 14'h2AD5);
		wr(OFF_DIR3, 32'hA);
		wr(OFF_OUT3, 32'hF);
		chk({P3_OE, P3_O & P3_OE}, 8'hAA);
		wr(OFF_DIR5, 32'hF);
		wr(OFF_OUT5, 32'h5);
		chk({P5_OE, P5_O}, 8'hA0);
		wr(OFF_OUT5, 32'h0);
		chk({P5_OE, pin[22:19]}, 8'hF0);
		rdc(OFF_DIR2, 32'h55);
	endtask : t_dir
	task t_pull();
		wr(OFF_WPU, 32'h2);
		chk({P0_PU, P1_PU}, 8'h0A);
		wr(OFF_PU2, 32'h7F);
		chk(P2_PU, 7'h2A);
		wr(OFF_PU3, 32'h3);
		chk(P3_PU, 4'h1);
		rdc(OFF_PU3, 32'h3);
	endtask : t_pull
	task t_key();
		drive(23'h00000F, 23'h00000F, 8'h00);
		wr(OFF_STS, 32'h1F);
		wr(OFF_CTL0, 32'hF);
		drive(23'h00000F, 23'h00000A, 8'h00);
		tick(6);
		chk(KEY_RETURN_INPUTS, 4'hA);
		rdc(OFF_STS, 32'h10);
		wr(OFF_CTL0, 32'h0);
		tick(2);
		chk(KEY_RETURN_INPUTS, 4'hF);
	endtask : t_key
	task t_ctl2();
		drive(23'h002D00, 23'h002900, 8'h91);
		wr(OFF_DIR2, 32'h52);
		wr(OFF_OUT2, 32'h0);
		wr(OFF_CTL2, 32'h7F);
		tick(4);
		chk({P2_O & P2_OE, rin}, 14'h2158);
		wr(OFF_CTL2, 32'hFF);
		tick(4);
		chk({P2_O & P2_OE, rin}, 14'h2946);
		drive(23'h002D00, 23'h000400, 8'h6E);
		tick(4);
		chk({P2_O & P2_OE, rin}, 14'h0020);
		wr(OFF_CTL2, 32'h0);
		tick(3);
		chk(rin, 7'h00);
	endtask : t_ctl2
	task t_ctl3();
		drive(23'h078000, 23'h000000, 8'h00);
		wr(OFF_DIR3, 32'h0);
		wr(OFF_EDGE, 32'h65);
		wr(OFF_MSK, 32'hF);
		wr(OFF_CTL3, 32'hF);
		wr(OFF_STS, 32'h1F);
		drive(23'h078000, 23'h078000, 8'h00);
		tick(6);
		rdc(OFF_STS, 32'h5);
		chk({IRQ, rin}, 8'h81);
		wr(OFF_STS, 32'h5);
		rdc(OFF_STS, 32'h0);
		wr(OFF_MSK, 32'h0);
		drive(23'h078000, 23'h000000, 8'h00);
		tick(6);
		rdc(OFF_STS, 32'h6);
		chk(IRQ, 1'b0);
		wr(OFF_MSK, 32'h2);
		tick(1);
		chk(IRQ, 1'b1);
		drive(23'h000000, 23'h000000, 8'h40);
		wr(OFF_DIR3, 32'h6);
		tick(2);
		chk({P3_OE, P3_O & P3_OE}, 8'h62);
		drive(23'h000000, 23'h000000, 8'h20);
		tick(2);
		chk({P3_OE, P3_O & P3_OE}, 8'h64);
		wr(8'h48, 32'hFFFFFFFF);
		rdc(8'h48, 32'h0);
	endtask : t_ctl3
	task t_rst();
		@(posedge SYS_CLK);
		RESETN <= 1'b0;
		tick(2);
		chk({P1_OE, P2_OE, P3_OE, IRQ}, 16'h0);
		@(posedge SYS_CLK);
		RESETN <= 1'b1;
		tick(1);
		rdc(OFF_DIR3, 32'h0);
	endtask : t_rst
	// Main sequence.
	initial begin
		RESETN = 1'b0;
		{HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
		HSIZE = HSIZE_WORD;
		{drv_en, drv_val, per} = '0;
		repeat (12) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		tick(1);
		t_reset();
		t_dir();
		t_pull();
		t_key();
		t_ctl2();
		t_ctl3();
		t_rst();
		stop_test();
	end
	// A hang costs at most a few thousand cycles, far beyond the planned run.
	initial begin
		repeat (4000) @(posedge SYS_CLK);
		err_total++;
		stop_test();
	end
endmodule : test_port_pin_mux_block
